// >>> cis_cfg.svh
// constants of the core interrupt and status block: offsets, bit positions, resets, vectors
// assumes inclusion by the core, flag and phase modules, one 32-bit ahb-lite word per register
`ifndef CIS_CFG_SVH
`define CIS_CFG_SVH
// register indices as the core sees them, byte address is four times the index
`define CIS_IDX_FLAGS      8'h0A
`define CIS_IDX_IRQ        8'h0B
`define CIS_IDX_CORE       8'h0C
`define CIS_IDX_STACK      8'h0D
`define CIS_ADDR_FLAGS     12'h028
`define CIS_ADDR_IRQ       12'h02C
`define CIS_ADDR_CORE      12'h030
`define CIS_ADDR_STACK     12'h034
// condition flag bit positions
`define CIS_BIT_C          0
`define CIS_BIT_AC         1
`define CIS_BIT_Z          2
`define CIS_BIT_OV         3
`define CIS_BIT_PD         4
`define CIS_BIT_TO         5
// interrupt control bit positions
`define CIS_BIT_GIE        0
`define CIS_BIT_EXT_EN     1
`define CIS_BIT_TA_EN      2
`define CIS_BIT_TB_EN      3
`define CIS_BIT_EXT_PEND   4
`define CIS_BIT_TA_PEND    5
`define CIS_BIT_TB_PEND    6
// reset values and masks
`define CIS_RST_IRQ        8'h00
`define CIS_RST_FLAGS      8'h00
`define CIS_IRQ_RW_MASK    8'h7F
`define CIS_FLAGS_SW_MASK  8'h0F
// call vectors
`define CIS_VEC_EXT        15'h0004
`define CIS_VEC_TA         15'h0008
`define CIS_VEC_TB         15'h000C
// stack depth and sample divider
`define CIS_STACK_DEPTH    4'h8
`define CIS_PHASE_DIV      2'h3
`endif

// >>> cis_core_irq.sv
// Function
// - falling edge on the external pin sets the external pending flag, bit 4.
// - enabled external request with stack room pushes pc and calls 04h.
// - external acknowledge clears its pending flag and the global enable.
// - timer a overflow sets bit 5; enabled service calls 08h, clearing flag and global.
// - timer b overflow sets bit 6; enabled service calls 0ch, clearing flag and global.
// - priority: external first, timer a second, timer b third.
// - full stack keeps flags but withholds acknowledge until a return pops.
// - flags stay until acknowledged or cleared by software; blocked requests still recorded.
// - acknowledge needs both the global enable and the source enable.
// - software re-enabling inside a handler allows nesting if stack has room.
// - interrupt return pops pc and sets global enable; plain return leaves it.
// - entry and calls push only the pc, no status.
// - requests between two sample pulses are taken at the second pulse.
// - any of the three sources wakes the core from power-down.
// - carry, bit 0: add carry out, subtract no borrow, rotate through carry.
// - half carry, bit 1: low nibble carry out or no high nibble borrow.
// - zero, bit 2: set when the result is zero.
// - overflow, bit 3: carry into msb differs from carry out.
// - power-down, bit 4: cleared by power-up or watchdog clear, set by halt.
// - time-out, bit 5: cleared by power-up, watchdog clear, halt; set by time-out.
// - software writes change arithmetic flags only, never power-down or time-out.
// - control bits: global 0, external 1, timer a 2, timer b 3, active high.
// - control bit 7 reads as zero.
// top of the interrupt sequencer and status flags, with an ahb-lite register slave
// assumes the core sequencer sends one-cycle commands on hclk and takes ack pulses
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "cis_cfg.svh"
module cis_core_irq
    import cis_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        ext_irq_n,
    input  wire logic        tmr_a_ovf,
    input  wire logic        tmr_b_ovf,
    input  cis_cmd_t         cmd,
    input  cis_alu_t         alu,
    input  wire logic [14:0] pc_in,
    output logic             ack_ff,
    output logic [14:0]      ack_vec_ff,
    output logic             push_ff,
    output logic [14:0]      push_pc_ff,
    output logic             pop_ff,
    output logic             halted_ff,
    output logic             wake_ff,
    output logic [7:0]       flags_ff,
    output logic [7:0]       irq_ctl_ff
);
    typedef struct packed {
        logic [1:0]  ext_sync;
        logic        ext_prev;
        logic [3:0]  stack_pointer;
        logic [7:0]  irq;
        logic [3:0]  arith;
        logic        pd;
        logic        to;
        logic        halted;
        logic        wake;
        logic        ack;
        logic [14:0] ack_vec;
        logic        push;
        logic [14:0] push_pc;
        logic        pop;
        logic        dp_act;
        logic        dp_wr;
        logic [11:0] dp_addr;
        logic [31:0] rdata;
    } cis_state_t;

    cis_state_t st_ff;
    cis_state_t nxt_st;
    logic       sample_phase_pulse;
    logic [3:0] alu_flags;
    logic [7:0] wr_byte;
    logic       ext_fall;
    logic       stack_full;
    logic       pick_ext;
    logic       pick_ta;
    logic       pick_tb;
    logic       ap_valid;

    // pick the readable word for a register address
    function automatic logic [31:0] read_word(input logic [11:0] a, input cis_state_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            `CIS_ADDR_FLAGS: w = {24'h00_0000, 2'h0, s.to, s.pd, s.arith};
            `CIS_ADDR_IRQ:   w = {24'h00_0000, 1'b0, s.irq[6:0]};
            `CIS_ADDR_CORE:  w = {30'h0000_0000, s.wake, s.halted};
            `CIS_ADDR_STACK: w = {28'h000_0000, s.stack_pointer};
            default:         w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    cis_phase_gen u_phase (
        .hclk               (hclk),
        .hresetn            (hresetn),
        .sample_phase_pulse (sample_phase_pulse)
    );

    cis_flag_unit u_flags (
        .alu (alu),
        .cur (st_ff.arith),
        .nxt (alu_flags)
    );

    // decode helpers; only the second sync stage feeds the edge detector
    always_comb begin
        ap_valid   = hsel && hready && htrans[1];
        wr_byte    = hwdata[7:0];
        ext_fall   = st_ff.ext_prev && !st_ff.ext_sync[1];
        stack_full = (st_ff.stack_pointer == `CIS_STACK_DEPTH);
        pick_ext   = st_ff.irq[`CIS_BIT_GIE] && st_ff.irq[`CIS_BIT_EXT_EN] && st_ff.irq[`CIS_BIT_EXT_PEND];
        pick_ta    = st_ff.irq[`CIS_BIT_GIE] && st_ff.irq[`CIS_BIT_TA_EN] && st_ff.irq[`CIS_BIT_TA_PEND];
        pick_tb    = st_ff.irq[`CIS_BIT_GIE] && st_ff.irq[`CIS_BIT_TB_EN] && st_ff.irq[`CIS_BIT_TB_PEND];
    end

    // next state of the whole block
    always_comb begin
        nxt_st          = st_ff;
        nxt_st.ext_sync = {st_ff.ext_sync[0], ext_irq_n};
        nxt_st.ext_prev = st_ff.ext_sync[1];
        nxt_st.ack      = 1'b0;
        nxt_st.push     = 1'b0;
        nxt_st.pop      = 1'b0;
        nxt_st.wake     = 1'b0;

        // bus data phase: software writes land first, hardware events override below
        if (st_ff.dp_act && st_ff.dp_wr) begin
            if (st_ff.dp_addr == `CIS_ADDR_IRQ) begin
                nxt_st.irq = wr_byte & `CIS_IRQ_RW_MASK;
            end
            if (st_ff.dp_addr == `CIS_ADDR_FLAGS) begin
                nxt_st.arith = wr_byte[3:0];
            end
        end
        nxt_st.dp_act  = ap_valid;
        nxt_st.dp_wr   = hwrite;
        nxt_st.dp_addr = haddr;
        nxt_st.rdata   = read_word(haddr, st_ff);

        // alu flags, overriding any bus write to the flags that is in its data phase
        if (alu.valid) begin
            nxt_st.arith = alu_flags;
        end

        // power-down and time-out flags move only on their own events
        if (cmd.wdt_clear) begin
            nxt_st.pd = 1'b0;
            nxt_st.to = 1'b0;
        end
        if (cmd.halt) begin
            nxt_st.pd     = 1'b1;
            nxt_st.to     = 1'b0;
            nxt_st.halted = 1'b1;
        end
        if (cmd.wdt_timeout) begin
            nxt_st.to = 1'b1;
        end

        // stack bookkeeping: only the pc goes on the stack
        if (cmd.call) begin
            nxt_st.push    = 1'b1;
            nxt_st.push_pc = pc_in;
            if (!stack_full) begin
                nxt_st.stack_pointer = st_ff.stack_pointer + 4'h1;
            end
        end
        if (cmd.ret_plain || cmd.ret_irq) begin
            nxt_st.pop = 1'b1;
            if (st_ff.stack_pointer != 4'h0) begin
                nxt_st.stack_pointer = st_ff.stack_pointer - 4'h1;
            end
        end
        if (cmd.ret_irq) begin
            nxt_st.irq[`CIS_BIT_GIE] = 1'b1;
        end

        // acknowledge at a sample pulse; flags latched since the previous pulse count
        if (sample_phase_pulse && !stack_full && !cmd.call && (pick_ext || pick_ta || pick_tb)) begin
            nxt_st.ack           = 1'b1;
            nxt_st.push          = 1'b1;
            nxt_st.push_pc       = pc_in;
            nxt_st.stack_pointer = nxt_st.stack_pointer + 4'h1;              // a return in this cycle nets out
            nxt_st.halted        = 1'b0;
            nxt_st.irq[`CIS_BIT_GIE] = 1'b0;
            if (pick_ext) begin
                nxt_st.ack_vec                = `CIS_VEC_EXT;
                nxt_st.irq[`CIS_BIT_EXT_PEND] = 1'b0;
            end else if (pick_ta) begin
                nxt_st.ack_vec               = `CIS_VEC_TA;
                nxt_st.irq[`CIS_BIT_TA_PEND] = 1'b0;
            end else begin
                nxt_st.ack_vec               = `CIS_VEC_TB;
                nxt_st.irq[`CIS_BIT_TB_PEND] = 1'b0;
            end
        end

        // source events set the pending flags last, so a set beats a clear
        if (ext_fall) begin
            nxt_st.irq[`CIS_BIT_EXT_PEND] = 1'b1;
        end
        if (tmr_a_ovf) begin
            nxt_st.irq[`CIS_BIT_TA_PEND] = 1'b1;
        end
        if (tmr_b_ovf) begin
            nxt_st.irq[`CIS_BIT_TB_PEND] = 1'b1;
        end
        nxt_st.irq[7] = 1'b0;

        // any source event ends power-down
        if (st_ff.halted && (ext_fall || tmr_a_ovf || tmr_b_ovf)) begin
            nxt_st.halted = 1'b0;
            nxt_st.wake   = 1'b1;
        end
    end

    // register the whole state; reset clears enables and flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff          <= '0;
            st_ff.ext_sync <= 2'h3;
            st_ff.ext_prev <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state flip-flops
    always_comb begin
        hrdata     = st_ff.rdata;
        hreadyout  = 1'b1;     // zero wait states
        hresp      = 1'b0;     // always okay
        ack_ff     = st_ff.ack;
        ack_vec_ff = st_ff.ack_vec;
        push_ff    = st_ff.push;
        push_pc_ff = st_ff.push_pc;
        pop_ff     = st_ff.pop;
        halted_ff  = st_ff.halted;
        wake_ff    = st_ff.wake;
        flags_ff   = {2'h0, st_ff.to, st_ff.pd, st_ff.arith};
        irq_ctl_ff = st_ff.irq;
    end
endmodule // cis_core_irq

// >>> cis_core_irq_properties.sv
// checker of the interrupt sequencer and condition flags
// assumes it is bound to cis_core_irq and sees only its ports
`timescale 1ns/1ps
module cis_core_irq_properties
    import cis_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        ext_irq_n,
    input wire logic        tmr_a_ovf,
    input cis_cmd_t         cmd,
    input wire logic        ack_ff,
    input wire logic [14:0] ack_vec_ff,
    input wire logic        push_ff,
    input wire logic        pop_ff,
    input wire logic        halted_ff,
    input wire logic        wake_ff,
    input wire logic [7:0]  flags_ff,
    input wire logic [7:0]  irq_ctl_ff
);
    // every check runs on hclk and rests while reset is low
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    top_bits_zero_a: assert property (flags_ff[7:6] == 2'h0 && !irq_ctl_ff[7])
        else $error("unused bits read as one");
    ack_clear_a: assert property (ack_ff |-> $past(irq_ctl_ff[0]) && !irq_ctl_ff[0])
        else $error("acknowledge without global enable or global left set");
    ack_ext_a: assert property (ack_ff && ack_vec_ff == 15'h0004 |->
        $past(irq_ctl_ff[4] && irq_ctl_ff[1]) && !irq_ctl_ff[4])
        else $error("external call without enabled pending flag");
    ack_ta_a: assert property (ack_ff && ack_vec_ff == 15'h0008 |->
        $past(irq_ctl_ff[5] && irq_ctl_ff[2] && !(irq_ctl_ff[4] && irq_ctl_ff[1])))
        else $error("timer a call out of priority");
    ack_tb_a: assert property (ack_ff && ack_vec_ff == 15'h000C |->
        $past(irq_ctl_ff[6] && irq_ctl_ff[3] && (irq_ctl_ff[5:4] & irq_ctl_ff[2:1]) == 2'h0))
        else $error("timer b call out of priority");
    ack_push_a: assert property (ack_ff |-> push_ff)
        else $error("acknowledge without push");
    tmr_flag_a: assert property (tmr_a_ovf |=> irq_ctl_ff[5])
        else $error("timer a overflow not recorded");
    ext_edge_a: assert property ($fell(ext_irq_n) |-> ##[2:4] irq_ctl_ff[4])
        else $error("external falling edge not recorded");
    no_global_a: assert property (!irq_ctl_ff[0] |=> !ack_ff)
        else $error("acknowledge while globally disabled");
    return_from_irq_instr_a: assert property (cmd.ret_irq |=> pop_ff && irq_ctl_ff[0])
        else $error("interrupt return did not pop and enable");
    halt_pd_a: assert property (cmd.halt && !cmd.wdt_timeout |=> halted_ff && flags_ff[5:4] == 2'h1)
        else $error("halt did not set power-down");
    wake_a: assert property (halted_ff && tmr_a_ovf |-> ##[1:8] wake_ff)
        else $error("timer a did not wake");
    // main scenarios reached
    cover property (ack_ff && ack_vec_ff == 15'h000C);
    cover property (wake_ff);
    cover property (cmd.ret_plain ##1 pop_ff);
endmodule // cis_core_irq_properties

bind cis_core_irq cis_core_irq_properties u_cis_core_irq_properties (.hclk(hclk), .hresetn(hresetn),
    .ext_irq_n(ext_irq_n), .tmr_a_ovf(tmr_a_ovf), .cmd(cmd), .ack_ff(ack_ff), .ack_vec_ff(ack_vec_ff),
    .push_ff(push_ff), .pop_ff(pop_ff), .halted_ff(halted_ff), .wake_ff(wake_ff), .flags_ff(flags_ff),
    .irq_ctl_ff(irq_ctl_ff));

// >>> cis_core_irq_tb.sv
// self-checking bench of the interrupt sequencer and condition flags
// assumes cis_core_irq, cis_seq_model and the bound checker
`timescale 1ns/1ps
module cis_core_irq_tb
    import cis_pkg::*;
;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, ext_irq_n, tmr_a_ovf, tmr_b_ovf;
    logic        ack_ff, push_ff, pop_ff, halted_ff, wake_ff;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic [14:0] pc_in, ack_vec_ff, push_pc_ff;
    logic [7:0]  flags_ff, irq_ctl_ff;
    cis_cmd_t    cmd;
    cis_alu_t    alu;
    int          n_fail, n_checks, n_push;

    cis_core_irq u_cis_core_irq (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext_irq_n, .tmr_a_ovf, .tmr_b_ovf, .cmd, .alu,
        .pc_in, .ack_ff, .ack_vec_ff, .push_ff, .push_pc_ff, .pop_ff, .halted_ff, .wake_ff, .flags_ff,
        .irq_ctl_ff);
    cis_seq_model u_cis_seq_model (.hclk, .hresetn, .ack_ff, .ack_vec_ff, .push_ff, .push_pc_ff,
        .pop_ff, .pc_in, .n_push);

    // 250 MHz clock
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // edges until hready, bounded
    task automatic wait_rdy();
        for (int i = 0; i < 50; i++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) return;
        end
        n_fail++;
        end_of_test();
    endtask

    // one single word transfer, read data left in rd
    task automatic ahb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask

    // one-cycle source events and sequencer command, then one settling edge
    task automatic pulse(input logic [2:0] e, input logic [5:0] c);
        @(posedge hclk);
        ext_irq_n <= !e[0];
        tmr_a_ovf <= e[1];
        tmr_b_ovf <= e[2];
        cmd <= c;
        @(posedge hclk);
        ext_irq_n <= 1'b1;
        tmr_a_ovf <= 1'b0;
        tmr_b_ovf <= 1'b0;
        cmd <= '0;
        @(posedge hclk);
    endtask

    task automatic alu_op(input cis_alu_t v);
        @(posedge hclk);
        alu <= v;
        @(posedge hclk);
        alu <= '0;
        @(posedge hclk);
    endtask

    task automatic wait_ack(input logic [14:0] v);
        for (int i = 0; i < 16; i++) begin
            @(posedge hclk);
            if (ack_ff === 1'b1) break;
        end
        if (ack_ff !== 1'b1) begin
            n_fail++;
            end_of_test();
        end
        chk(ack_vec_ff, v);
    endtask

    task automatic t_reset();
        ahb(12'h028, 1'b0, 32'h0);
        chk(rd, 32'h0);
        ahb(12'h02C, 1'b0, 32'h0);
        chk(rd, 32'h0);
        ahb(12'h040, 1'b1, 32'hFF);
        ahb(12'h040, 1'b0, 32'h0);
        chk(rd, 32'h0);
    endtask

    // expected flags {ov, z, ac, c} worked out by hand for each operand pair
    task automatic t_flags();
        logic [7:0] av [5] = '{8'hFF, 8'h7F, 8'h05, 8'h03, 8'h80};
        logic [7:0] bv [5] = '{8'h01, 8'h01, 8'h03, 8'h05, 8'h80};
        logic [7:0] rv [5] = '{8'h00, 8'h80, 8'h02, 8'hFE, 8'h00};
        logic [3:0] ev [5] = '{4'h7, 4'hA, 4'h3, 4'h0, 4'hD};
        logic [4:0] sv = 5'h0C;
        for (int i = 0; i < 5; i++) begin
            alu_op('{1'b1, 1'b1, sv[i], 1'b0, 1'b0, av[i], bv[i], sv[i], rv[i]});
            chk(flags_ff[3:0], ev[i]);
        end
        alu_op('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h0F, 8'hF0, 1'b0, 8'h00});
        chk(flags_ff[2], 1'b1);
        alu_op('{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 8'h81, 8'h00, 1'b0, 8'h03});
        chk(flags_ff[0], 1'b0);
    endtask

    // halt, then let one source end the power-down
    task automatic wake_by(input logic [2:0] e);
        pulse(3'h0, 6'h20);
        chk({halted_ff, flags_ff[5:4]}, 3'h5);
        ahb(12'h030, 1'b0, 32'h0);
        chk(rd, 32'h1);
        pulse(e, 6'h00);
        for (int i = 0; i < 16 && halted_ff !== 1'b0; i++) @(posedge hclk);
        chk({halted_ff, wake_ff}, 2'h1);
    endtask

    task automatic t_status();
        wake_by(3'h1);
        pulse(3'h0, 6'h08);
        chk(flags_ff[5:4], 2'h3);
        ahb(12'h028, 1'b1, 32'hC0);
        ahb(12'h028, 1'b0, 32'h0);
        chk(rd, 32'h30);
        ahb(12'h028, 1'b1, 32'hFF);
        ahb(12'h028, 1'b0, 32'h0);
        chk(rd, 32'h3F);
        wake_by(3'h2);
        wake_by(3'h4);
        pulse(3'h0, 6'h10);
        chk(flags_ff[5:4], 2'h0);
        ahb(12'h02C, 1'b1, 32'h0);
    endtask

    task automatic t_prio();
        pulse(3'h7, 6'h00);
        ahb(12'h02C, 1'b0, 32'h0);
        chk(rd, 32'h70);
        ahb(12'h02C, 1'b1, 32'hFF);
        wait_ack(15'h0004);
        chk(irq_ctl_ff, 8'h6E);
        ahb(12'h02C, 1'b1, 32'h6F);
        wait_ack(15'h0008);
        chk(irq_ctl_ff, 8'h4E);
        pulse(3'h0, 6'h02);
        wait_ack(15'h000C);
        chk(irq_ctl_ff, 8'h0E);
        pulse(3'h0, 6'h04);
        chk(irq_ctl_ff[0], 1'b0);
        ahb(12'h034, 1'b0, 32'h0);
        chk(rd, 32'h1);
        chk(n_push, 3);
    endtask

    task automatic t_full();
        repeat (7) pulse(3'h0, 6'h01);
        ahb(12'h034, 1'b0, 32'h0);
        chk(rd, 32'h8);
        ahb(12'h02C, 1'b1, 32'h05);
        pulse(3'h2, 6'h00);
        repeat (12) begin
            @(posedge hclk);
            chk(ack_ff, 1'b0);
        end
        chk(irq_ctl_ff, 8'h25);
        pulse(3'h0, 6'h04);
        wait_ack(15'h0008);
    endtask

    // second reset in mid-run, with all flags set and the stack full
    task automatic t_rerst();
        ahb(12'h02C, 1'b1, 32'h7F);
        @(posedge hclk);
        chk(irq_ctl_ff, 8'h7F);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk({flags_ff, irq_ctl_ff}, 16'h0000);
        hresetn <= 1'b1;
        ahb(12'h034, 1'b0, 32'h0);
        chk(rd, 32'h0);
        chk({halted_ff, flags_ff, irq_ctl_ff}, 17'h00000);
    endtask

    // inputs at time zero, reset for 20 cycles, then the scenarios
    initial begin
        {hresetn, hwrite, tmr_a_ovf, tmr_b_ovf, n_fail, n_checks} = '0;
        {hsel, ext_irq_n} = 2'h3;
        haddr = 12'h000;
        htrans = 2'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        cmd = '0;
        alu = '0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_flags();
        t_status();
        t_prio();
        t_full();
        t_rerst();
        end_of_test();
    end

    // hang guard
    initial begin
        #400000;
        n_fail++;
        end_of_test();
    end
endmodule // cis_core_irq_tb

// >>> cis_flag_unit.sv
// condition flag computation from one alu result
// assumes the alu result is on the same clock and valid for one cycle
`timescale 1ns/1ps
`include "cis_cfg.svh"
module cis_flag_unit
    import cis_pkg::*;
(
    input  cis_alu_t   alu,
    input  logic [3:0] cur,
    output logic [3:0] nxt
);
    logic [8:0] sum;
    logic [4:0] lo;
    logic [7:0] low7;
    logic [7:0] bop;
    // subtraction adds the inverted operand, so carry means no borrow
    always_comb begin
        bop  = alu.sub ? ~alu.b : alu.b;
        sum  = {1'b0, alu.a} + {1'b0, bop} + {8'h00, alu.cin};
        lo   = {1'b0, alu.a[3:0]} + {1'b0, bop[3:0]} + {4'h0, alu.cin};
        low7 = {1'b0, alu.a[6:0]} + {1'b0, bop[6:0]} + {7'h00, alu.cin};
        nxt  = cur;
        if (alu.valid) begin
            nxt[`CIS_BIT_Z] = (alu.result == 8'h00);
            if (alu.arith) begin
                nxt[`CIS_BIT_C]  = sum[8];
                nxt[`CIS_BIT_AC] = lo[4];
                nxt[`CIS_BIT_OV] = low7[7] ^ sum[8];
            end
            if (alu.rot) begin
                nxt[`CIS_BIT_C] = alu.rot_c;
            end
        end
    end
endmodule // cis_flag_unit

// >>> cis_phase_gen.sv
// divider that makes the sample phase enable pulse
// assumes one clock, hclk, and an active low asynchronous reset
`timescale 1ns/1ps
`include "cis_cfg.svh"
module cis_phase_gen
    import cis_pkg::*;
(
    input  wire logic hclk,
    input  wire logic hresetn,
    output logic      sample_phase_pulse
);
    typedef struct packed {
        logic [1:0] cnt;
        logic       pulse;
    } cis_phase_st_t;
    cis_phase_st_t st_ff;
    cis_phase_st_t nxt_st;
    // count hclk and emit one pulse every fourth cycle
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.pulse = (st_ff.cnt == `CIS_PHASE_DIV);
        nxt_st.cnt   = st_ff.cnt + 2'h1;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign sample_phase_pulse = st_ff.pulse;
endmodule // cis_phase_gen

// >>> cis_pkg.sv
// types of the core interrupt and status block
// assumes cis_cfg.svh holds the numeric constants
package cis_pkg;
    typedef enum logic [1:0] {
        CIS_SRC_NONE = 2'h0,
        CIS_SRC_EXT  = 2'h1,
        CIS_SRC_TA   = 2'h3,
        CIS_SRC_TB   = 2'h2
    } cis_src_t;
    // one-cycle commands from the core sequencer
    typedef struct packed {
        logic halt;
        logic wdt_clear;
        logic wdt_timeout;
        logic ret_plain;
        logic ret_irq;
        logic call;
    } cis_cmd_t;
    // alu result to be folded into the condition flags
    typedef struct packed {
        logic       valid;
        logic       arith;
        logic       sub;
        logic       rot;
        logic       rot_c;
        logic [7:0] a;
        logic [7:0] b;
        logic       cin;
        logic [7:0] result;
    } cis_alu_t;
    typedef struct packed {
        logic       req;
        logic [14:0] vec;
        cis_src_t   src;
    } cis_ack_t;
endpackage

// >>> cis_seq_model.sv
// behavioural core sequencer with an eight-entry return stack
// assumes the block's push, pop and acknowledge pulses on hclk
`timescale 1ns/1ps
module cis_seq_model (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        ack_ff,
    input wire logic [14:0] ack_vec_ff,
    input wire logic        push_ff,
    input wire logic [14:0] push_pc_ff,
    input wire logic        pop_ff,
    output logic [14:0]     pc_in,
    output int              n_push
);
    logic [14:0] stk [$];
    // pc steps each cycle, jumps on acknowledge; oldest entry is lost past eight
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_in <= 15'h0000;
            n_push <= 0;
            stk.delete();
        end else begin
            pc_in <= ack_ff ? ack_vec_ff : pc_in + 15'h0001;
            if (push_ff) begin
                n_push <= n_push + 1;
                stk.push_back(push_pc_ff);
                if (stk.size() > 8) void'(stk.pop_front());
            end
            if (pop_ff && stk.size() > 0) pc_in <= stk.pop_back();
        end
    end
endmodule // cis_seq_model
